// ### verilog/scp_defs.vh
// Function
// R1: Eight pins each take one of four roles.
// R2: Pin roles come only from configuration registers.
// R3: Analog output pins use 12-bit DAC, span selectable.
// R4: Analog inputs muxed to shared 12-bit ADC.
// R5: Shared converter sustains 400 kSPS aggregate.
// R6: Internal reference stays off until software enables.
// R7: Output levels written, input levels read serially.
// R8: Results, readback and temperature leave on serial_out.
// R9: Output bits shift on serial clock rising edges.
// R10: Frame start presents output MSB at once.
// R11: Next bit on first rise after a fall.
// R12: Input bits sampled on serial clock falling edges.
// R13: Frame select low; sixteen falling edges form frame.
// R14: Host limits clock to 50/20 MHz.
// R15: Reset pin low asynchronously restores configuration defaults.
// R16: Top pin may show converter busy.
// R17: Temperature arrives within the ADC readback sequence.
// R18: Act only on complete frames; discard abandoned ones.
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// Timing.
`define SCP_CLK_KHZ      250000
`define SCP_ADC_KSPS     400
`define SCP_CONV_CYC     (`SCP_CLK_KHZ / `SCP_ADC_KSPS)
`define SCP_FRAME_BITS   5'h10

// Serial command word layout.
`define SCP_CMD_DAC      15
`define SCP_CMD_CH_HI    14
`define SCP_CMD_CH_LO    12
`define SCP_CMD_ADR_HI   14
`define SCP_CMD_ADR_LO   11

// Serial register addresses.
`define SCP_SR_NOP       4'h0
`define SCP_SR_SEQ       4'h2
`define SCP_SR_CTRL      4'h3
`define SCP_SR_ADC_CFG   4'h4
`define SCP_SR_DAC_CFG   4'h5
`define SCP_SR_RB        4'h6
`define SCP_SR_GPO_CFG   4'h8
`define SCP_SR_GPO_DAT   4'h9
`define SCP_SR_GPI_CFG   4'ha
`define SCP_SR_REF       4'hb
`define SCP_SR_SRST      4'hf
`define SCP_SRST_KEY     11'h5ac

// Field positions.
`define SCP_SEQ_TEMP     8
`define SCP_SEQ_REP      9
`define SCP_CTRL_DSPAN   4
`define SCP_CTRL_ASPAN   5
`define SCP_CTRL_BUSY    8
`define SCP_RB_EN        6
`define SCP_GPI_RB       10
`define SCP_REF_EN       9
`define SCP_TEMP_CH      4'h8
`define SCP_NO_CH        4'hf

// APB offsets and reset values.
`define SCP_APB_CTRL     8'h00
`define SCP_APB_STAT     8'h04
`define SCP_APB_LAST     8'h08
`define SCP_APB_RES      8'h0c
`define SCP_CTRL_RST     1'h1

`endif

// ### verilog/scp_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for inputs from outside the clock domain.
module scp_sync #(
   parameter W = 1
) (
   input  wire         i_clk_sys,
   input  wire         i_rst,
   input  wire [W-1:0] i_d,
   output wire [W-1:0] o_q
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         s1 <= {W{1'b1}};
         s2 <= {W{1'b1}};
      end else begin
         s1 <= i_d;
         s2 <= s1;
      end
   end

   assign o_q = s2;
endmodule // scp_sync

// ### verilog/scp_top.v
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "scp_defs.vh"
module scp_top (
   input  wire        i_clk_sys,
   input  wire        i_rst,
   input  wire        i_reset_n,
   input  wire        i_sclk,
   input  wire        i_frame_n,
   input  wire        i_serial_in,
   output wire        o_serial_out,
   output wire        o_serial_out_oe,
   input  wire [7:0]  i_config_pin,
   output reg  [7:0]  o_config_pin,
   output reg  [7:0]  o_config_pin_oe,
   output wire [95:0] o_dac_val,
   output reg  [7:0]  o_dac_en,
   output wire        o_dac_span,
   output wire        o_adc_span,
   output wire        o_ref_en,
   output wire [3:0]  o_adc_chan,
   output wire        o_adc_busy,
   input  wire [11:0] i_adc_result,
   input  wire [11:0] i_temp_result,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr
);
   // ******************************
   // Pin synchronisation and edges
   // ******************************
   wire [10:0] sq;
   wire        sclk_q  = sq[10];
   wire        frame_q = sq[9];
   wire        sdi_q   = sq[8];
   wire [7:0]  pin_q   = sq[7:0];
   reg         sclk_d;
   reg         frame_d;

   scp_sync #(.W(11)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_d       ({i_sclk, i_frame_n, i_serial_in, i_config_pin}),
      .o_q       (sq)
   );

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         sclk_d  <= 1'b1;
         frame_d <= 1'b1;
      end else begin
         sclk_d  <= sclk_q;
         frame_d <= frame_q;
      end
   end

   wire sclk_fall   = sclk_d & ~sclk_q;
   wire sclk_rise   = ~sclk_d & sclk_q;
   wire frame_start = frame_d & ~frame_q;
   wire frame_act   = ~frame_q;

   // ******************************
   // Serial frame engine
   // ******************************
   reg         link_en;
   reg  [15:0] rx;
   reg  [15:0] tx;
   reg  [4:0]  bit_cnt;
   reg         seen_fall;
   reg  [15:0] last_cmd;
   wire [15:0] tx_word;
   wire        cmd_go = frame_act & ~frame_start & sclk_fall &
                        (bit_cnt == `SCP_FRAME_BITS - 5'h1) & link_en; // R13 R18
   wire [15:0] cmd = {rx[14:0], sdi_q};
   wire [3:0]  cmd_adr = cmd[`SCP_CMD_ADR_HI:`SCP_CMD_ADR_LO];
   wire [10:0] cmd_dat = cmd[10:0];
   wire        is_dac = cmd[`SCP_CMD_DAC];
   wire        reg_go = cmd_go & ~is_dac;

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         rx        <= 16'h0000;
         tx        <= 16'h0000;
         bit_cnt   <= 5'h00;
         seen_fall <= 1'b0;
         last_cmd  <= 16'h0000;
      end else if (frame_start) begin
         tx        <= tx_word; // R10
         bit_cnt   <= 5'h00;
         seen_fall <= 1'b0;
      end else if (frame_act) begin
         if (sclk_fall && bit_cnt < `SCP_FRAME_BITS) begin
            rx        <= cmd; // R12
            bit_cnt   <= bit_cnt + 5'h01; // R13
            seen_fall <= 1'b1;
         end else if (sclk_rise && seen_fall) begin
            tx        <= {tx[14:0], 1'b0}; // R9 R11
            seen_fall <= 1'b0;
         end
         if (cmd_go) begin
            last_cmd <= cmd;
         end
      end
   end

   assign o_serial_out    = tx[15]; // R8
   assign o_serial_out_oe = frame_act;

   // ******************************
   // Configuration registers
   // ******************************
   reg [7:0]  adc_mask;
   reg [7:0]  dac_mask;
   reg [7:0]  gpo_mask;
   reg [7:0]  gpi_mask;
   reg [7:0]  gpo_data;
   reg        ref_en;
   reg        dac_span;
   reg        adc_span;
   reg        busy_en;
   reg [7:0]  seq_mask;
   reg        seq_temp;
   reg        seq_rep;
   reg        seq_go;
   reg        rb_pend;
   reg [3:0]  rb_sel;
   reg [11:0] dac_val [0:7];
   integer    k;
   integer    j;
   wire       srst = reg_go && cmd_adr == `SCP_SR_SRST &&
                     cmd_dat == `SCP_SRST_KEY;

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin // R15
         adc_mask <= 8'h00;
         dac_mask <= 8'h00;
         gpo_mask <= 8'h00;
         gpi_mask <= 8'h00;
         gpo_data <= 8'h00;
         ref_en   <= 1'b0; // R6
         dac_span <= 1'b0;
         adc_span <= 1'b0;
         busy_en  <= 1'b0;
         seq_mask <= 8'h00;
         seq_temp <= 1'b0;
         seq_rep  <= 1'b0;
         seq_go   <= 1'b0;
         rb_pend  <= 1'b0;
         rb_sel   <= 4'h0;
         for (k = 0; k < 8; k = k + 1) begin
            dac_val[k] <= 12'h000;
         end
      end else if (i_rst || srst) begin
         adc_mask <= 8'h00;
         dac_mask <= 8'h00;
         gpo_mask <= 8'h00;
         gpi_mask <= 8'h00;
         gpo_data <= 8'h00;
         ref_en   <= 1'b0; // R6
         dac_span <= 1'b0;
         adc_span <= 1'b0;
         busy_en  <= 1'b0;
         seq_mask <= 8'h00;
         seq_temp <= 1'b0;
         seq_rep  <= 1'b0;
         seq_go   <= 1'b0;
         rb_pend  <= 1'b0;
         rb_sel   <= 4'h0;
         for (k = 0; k < 8; k = k + 1) begin
            dac_val[k] <= 12'h000;
         end
      end else begin
         seq_go <= 1'b0;
         if (frame_start) begin
            rb_pend <= 1'b0;
         end
         if (cmd_go && is_dac) begin
            dac_val[cmd[`SCP_CMD_CH_HI:`SCP_CMD_CH_LO]] <= cmd[11:0]; // R3
         end
         if (reg_go) begin // R2
            case (cmd_adr)
               `SCP_SR_SEQ: begin
                  seq_mask <= cmd_dat[7:0];
                  seq_temp <= cmd_dat[`SCP_SEQ_TEMP]; // R17
                  seq_rep  <= cmd_dat[`SCP_SEQ_REP];
                  seq_go   <= 1'b1;
               end
               `SCP_SR_CTRL: begin
                  dac_span <= cmd_dat[`SCP_CTRL_DSPAN]; // R3
                  adc_span <= cmd_dat[`SCP_CTRL_ASPAN]; // R4
                  busy_en  <= cmd_dat[`SCP_CTRL_BUSY]; // R16
               end
               `SCP_SR_ADC_CFG: adc_mask <= cmd_dat[7:0];
               `SCP_SR_DAC_CFG: dac_mask <= cmd_dat[7:0];
               `SCP_SR_RB: begin
                  rb_pend <= cmd_dat[`SCP_RB_EN];
                  rb_sel  <= cmd_dat[5:2];
               end
               `SCP_SR_GPO_CFG: gpo_mask <= cmd_dat[7:0];
               `SCP_SR_GPO_DAT: gpo_data <= cmd_dat[7:0]; // R7
               `SCP_SR_GPI_CFG: begin
                  gpi_mask <= cmd_dat[7:0];
                  if (cmd_dat[`SCP_GPI_RB]) begin // R7
                     rb_pend <= 1'b1;
                     rb_sel  <= `SCP_SR_GPI_CFG;
                  end
               end
               `SCP_SR_REF: ref_en <= cmd_dat[`SCP_REF_EN]; // R6
               default: begin
               end
            endcase
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_dac
         assign o_dac_val[g*12 +: 12] = dac_val[g];
      end
   endgenerate

   assign o_dac_span = dac_span;
   assign o_adc_span = adc_span;
   assign o_ref_en   = ref_en;

   // ******************************
   // Conversion sequencer
   // ******************************
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;
   reg        state;
   reg [9:0]  conv_cnt;
   reg [3:0]  conv_ch;
   reg [3:0]  res_tag;
   reg [11:0] res_val;
   wire [8:0] ch_mask = {seq_temp, seq_mask & adc_mask}; // R4 R17

   function [3:0] find_ch;
      input [3:0] from;
      input [8:0] m;
      integer     i;
      begin
         find_ch = `SCP_NO_CH;
         for (i = 8; i >= 0; i = i - 1) begin
            if (m[i] && i >= from) begin
               find_ch = i[3:0];
            end
         end
      end
   endfunction

   wire [3:0] nxt_ch = find_ch(conv_ch + 4'h1, ch_mask);
   wire [3:0] first  = find_ch(4'h0, ch_mask);
   wire [31:0] conv_full = `SCP_CONV_CYC - 1;
   wire [9:0]  conv_load = conv_full[9:0];

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin // R15
         state    <= ST_IDLE;
         conv_cnt <= 10'h000;
         conv_ch  <= 4'h0;
         res_tag  <= 4'h0;
         res_val  <= 12'h000;
      end else if (i_rst || srst) begin
         state    <= ST_IDLE;
         conv_cnt <= 10'h000;
         conv_ch  <= 4'h0;
         res_tag  <= 4'h0;
         res_val  <= 12'h000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (seq_go && first != `SCP_NO_CH) begin
                  state    <= ST_CONV;
                  conv_ch  <= first;
                  conv_cnt <= conv_load; // R5
               end
            end
            ST_CONV: begin
               if (seq_go) begin
                  state <= (first != `SCP_NO_CH) ? ST_CONV : ST_IDLE;
                  conv_ch  <= first;
                  conv_cnt <= conv_load;
               end else if (conv_cnt != 10'h000) begin
                  conv_cnt <= conv_cnt - 10'h001;
               end else begin
                  res_tag <= conv_ch;
                  res_val <= (conv_ch == `SCP_TEMP_CH) ?
                             i_temp_result : i_adc_result; // R17
                  conv_cnt <= conv_load; // R5
                  if (nxt_ch != `SCP_NO_CH) begin
                     conv_ch <= nxt_ch;
                  end else if (seq_rep && first != `SCP_NO_CH) begin
                     conv_ch <= first;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   wire busy = (state == ST_CONV);
   assign o_adc_busy = busy;
   assign o_adc_chan = conv_ch;

   // ******************************
   // Readback word and pin roles
   // ******************************
   reg [10:0] rb_val;

   always @* begin
      case (rb_sel)
         `SCP_SR_SEQ:     rb_val = {1'b0, seq_rep, seq_temp, seq_mask};
         `SCP_SR_CTRL:    rb_val = {2'b00, busy_en, 2'b00, adc_span,
                                    dac_span, 4'h0};
         `SCP_SR_ADC_CFG: rb_val = {3'b000, adc_mask};
         `SCP_SR_DAC_CFG: rb_val = {3'b000, dac_mask};
         `SCP_SR_GPO_CFG: rb_val = {3'b000, gpo_mask};
         `SCP_SR_GPO_DAT: rb_val = {3'b000, gpo_data};
         `SCP_SR_GPI_CFG: rb_val = {3'b000, pin_q & gpi_mask}; // R7
         `SCP_SR_REF:     rb_val = {1'b0, ref_en, 9'h000};
         default:         rb_val = 11'h000;
      endcase
   end

   assign tx_word = rb_pend ? {rb_sel, 1'b0, rb_val}
                            : {res_tag, res_val}; // R8 R17

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin // R15
         o_config_pin    <= 8'h00;
         o_config_pin_oe <= 8'h00;
         o_dac_en        <= 8'h00;
      end else if (i_rst) begin
         o_config_pin    <= 8'h00;
         o_config_pin_oe <= 8'h00;
         o_dac_en        <= 8'h00;
      end else begin
         for (j = 0; j < 8; j = j + 1) begin // R1 R2
            o_dac_en[j] <= dac_mask[j]; // R3
            if (j == 7 && busy_en) begin
               o_config_pin[j]    <= busy; // R16
               o_config_pin_oe[j] <= 1'b1;
            end else begin
               o_config_pin[j]    <= gpo_data[j]; // R7
               o_config_pin_oe[j] <= gpo_mask[j] & ~dac_mask[j] &
                                     ~adc_mask[j];
            end
         end
      end
   end

   // ******************************
   // APB slave
   // ******************************
   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pwrite;
   wire mapped    = paddr == `SCP_APB_CTRL || paddr == `SCP_APB_STAT ||
                    paddr == `SCP_APB_LAST || paddr == `SCP_APB_RES;

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         link_en <= `SCP_CTRL_RST;
         prdata  <= 32'h00000000;
      end else begin
         if (apb_wr && paddr == `SCP_APB_CTRL) begin
            link_en <= pwdata[0];
         end
         if (apb_setup) begin
            case (paddr)
               `SCP_APB_CTRL: prdata <= {31'h00000000, link_en};
               `SCP_APB_STAT: prdata <= {27'h0000000, rb_pend,
                                         frame_act, busy, ref_en,
                                         link_en};
               `SCP_APB_LAST: prdata <= {16'h0000, last_cmd};
               `SCP_APB_RES:  prdata <= {16'h0000, res_tag, res_val};
               default:       prdata <= 32'h00000000;
            endcase
         end
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
endmodule // scp_top

// ### tb/scp_chk_sva.sv
`timescale 1ns/1ps
`include "scp_defs.vh"
module scp_chk (
   input logic        i_clk_sys,
   input logic        i_rst,
   input logic        i_reset_n,
   input logic        i_sclk,
   input logic        i_frame_n,
   input logic        o_serial_out,
   input logic        o_serial_out_oe,
   input logic [7:0]  o_config_pin_oe,
   input logic [7:0]  o_dac_en,
   input logic        o_ref_en,
   input logic [3:0]  o_adc_chan,
   input logic        o_adc_busy,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] prdata,
   input logic        pslverr
);
   localparam int CONV = `SCP_CONV_CYC;
   logic [3:0]  pch;
   logic [10:0] cnt;
   // Cycles spent on the channel now under conversion.
   always @(posedge i_clk_sys) begin
      pch <= o_adc_chan;
      if (i_rst || !o_adc_busy || o_adc_chan != pch) cnt <= 11'h0;
      else cnt <= cnt + 11'h1;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   oe_on_a: assert property (!i_frame_n [*5] |-> o_serial_out_oe)
      else $error("serial out not enabled in frame");
   oe_off_a: assert property (i_frame_n [*5] |-> !o_serial_out_oe)
      else $error("serial out enabled outside frame");
   sdo_hold_a: assert property ((!i_frame_n && $stable(i_sclk)) [*6]
      |=> $stable(o_serial_out))
      else $error("serial out moved without a clock rise");
   err_scope_a: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   unmapped_a: assert property (psel && penable && !pwrite &&
      paddr > `SCP_APB_RES |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   status_a: assert property (psel && penable && !pwrite &&
      paddr == `SCP_APB_STAT |-> prdata[2:1] ==
      $past({o_adc_busy, o_ref_en}))
      else $error("status bits disagree with outputs");
   dac_pin_a: assert property ((o_dac_en[6:0] & o_config_pin_oe[6:0])
      == 7'h0)
      else $error("analog output pin also driven digitally");
   conv_max_a: assert property (cnt <= CONV + 2)
      else $error("conversion too slow");
   conv_min_a: assert property (o_adc_busy && $past(o_adc_busy) &&
      o_adc_chan != $past(o_adc_chan) |-> $past(cnt) >= CONV - 3)
      else $error("conversion too fast");
   chan_range_a: assert property (o_adc_busy |->
      o_adc_chan <= `SCP_TEMP_CH)
      else $error("channel out of range");
   cfg_reset_a: assert property ($fell(i_reset_n) |-> ##[0:3]
      (!o_ref_en && o_dac_en == 8'h0 && o_config_pin_oe == 8'h0))
      else $error("configuration not cleared by reset pin");
endmodule // scp_chk
bind scp_top scp_chk u_chk (.i_clk_sys, .i_rst, .i_reset_n, .i_sclk,
   .i_frame_n, .o_serial_out, .o_serial_out_oe, .o_config_pin_oe,
   .o_dac_en, .o_ref_en, .o_adc_chan, .o_adc_busy, .psel, .penable,
   .pwrite, .paddr, .prdata, .pslverr);

// ### tb/scp_host_model.sv
`timescale 1ns/1ps
module scp_host_model (
   input  logic i_clk,
   input  logic i_sdo,
   output logic o_sclk,
   output logic o_frame_n,
   output logic o_sdi
);
   initial begin
      o_sclk = 1'b1;
      o_frame_n = 1'b1;
      o_sdi = 1'b0;
   end
   task automatic hold();
      repeat (8) @(posedge i_clk);
   endtask
   // Sends n bits MSB first; a 64 ns clock period stays below both limits.
   task automatic xfer(input logic [15:0] w, input int n,
                       input logic idle, output logic [15:0] q);
      q = 16'h0;
      @(posedge i_clk);
      o_sclk <= idle;
      hold();
      o_frame_n <= 1'b0;
      hold();
      for (int i = 0; i < n; i++) begin
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_sdi <= w[15-i];
         repeat (4) @(posedge i_clk);
         q[15-i] = i_sdo;
         o_sclk <= 1'b0;
         hold();
      end
      o_sclk <= 1'b1;
      hold();
      o_frame_n <= 1'b1;
      o_sdi <= ~o_sdi;
      o_sclk <= idle;
      hold();
   endtask
endmodule // scp_host_model

// ### tb/tb.sv
`timescale 1ns/1ps
`include "scp_defs.vh"
module tb;
   logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_reset_n = 1'b1;
   logic        i_sclk, i_frame_n, i_serial_in, o_serial_out;
   logic        o_serial_out_oe, o_dac_span, o_adc_span, o_ref_en;
   logic        o_adc_busy, pready, pslverr, e;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  i_config_pin = 8'h40, o_config_pin, o_config_pin_oe;
   logic [7:0]  o_dac_en, paddr = 8'h0;
   logic [95:0] o_dac_val;
   logic [3:0]  o_adc_chan;
   logic [11:0] i_adc_result = 12'h123, i_temp_result = 12'h7e5;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] r;
   int          err_count = 0, n_checks = 0, n;
   always #2 i_clk_sys = ~i_clk_sys;
   scp_top DUT (.i_clk_sys, .i_rst, .i_reset_n, .i_sclk, .i_frame_n,
      .i_serial_in, .o_serial_out, .o_serial_out_oe, .i_config_pin,
      .o_config_pin, .o_config_pin_oe, .o_dac_val, .o_dac_en,
      .o_dac_span, .o_adc_span, .o_ref_en, .o_adc_chan, .o_adc_busy,
      .i_adc_result, .i_temp_result, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   scp_host_model host (.i_clk(i_clk_sys), .i_sdo(o_serial_out),
      .o_sclk(i_sclk), .o_frame_n(i_frame_n), .o_sdi(i_serial_in));
   task automatic chk(input string s, input logic [31:0] x,
                      input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic er);
      @(posedge i_clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      @(posedge i_clk_sys);
      while (pready !== 1'b1) @(posedge i_clk_sys);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] a, input logic [10:0] d);
      host.xfer({1'b0, a, d}, 16, 1'b1, r);
      repeat (4) @(posedge i_clk_sys);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      @(posedge i_clk_sys);
      chk("ref_en", 32'h0, o_ref_en);
      apb(1'b0, `SCP_APB_CTRL, 32'h0, rd, e);
      chk("ctrl", 32'h1, rd);
      apb(1'b0, `SCP_APB_STAT, 32'h0, rd, e);
      chk("status", 32'h1, rd);
      apb(1'b0, 8'h10, 32'h0, rd, e);
      chk("unmapped", 32'h1, {rd[30:0], e});
      $display("test reset done");
      cmd(`SCP_SR_GPO_CFG, 11'h00f);
      cmd(`SCP_SR_GPO_DAT, 11'h005);
      chk("gpo_oe", 32'h0f, o_config_pin_oe);
      chk("gpo", 32'h5, o_config_pin[3:0]);
      host.xfer({1'b0, `SCP_SR_GPO_DAT, 11'h00a}, 8, 1'b1, r);
      chk("abandoned", 32'h5, o_config_pin[3:0]);
      apb(1'b1, `SCP_APB_CTRL, 32'h0, rd, e);
      cmd(`SCP_SR_GPO_DAT, 11'h003);
      chk("link_off", 32'h5, o_config_pin[3:0]);
      apb(1'b1, `SCP_APB_CTRL, 32'h1, rd, e);
      $display("test gpo done");
      cmd(`SCP_SR_GPI_CFG, 11'h4c0);
      host.xfer(16'h0, 16, 1'b0, r);
      chk("gpi_rb", 32'ha040, r);
      $display("test gpi done");
      cmd(`SCP_SR_DAC_CFG, 11'h010);
      chk("dac_en", 32'h10, o_dac_en);
      host.xfer(16'hcabc, 16, 1'b1, r);
      repeat (4) @(posedge i_clk_sys);
      chk("dac_val", 32'habc, o_dac_val[59:48]);
      cmd(`SCP_SR_CTRL, 11'h130);
      chk("spans", 32'h3, {o_dac_span, o_adc_span});
      cmd(`SCP_SR_REF, 11'h200);
      chk("ref_on", 32'h1, o_ref_en);
      $display("test dac done");
      cmd(`SCP_SR_ADC_CFG, 11'h002);
      cmd(`SCP_SR_SEQ, 11'h102);
      chk("chan", 32'h1, o_adc_chan);
      chk("busy_pin", 32'h3, {o_config_pin[7], o_config_pin_oe[7]});
      n = 0;
      while (o_adc_busy === 1'b1 && n < 3000) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk("conv_len", 32'h1, n > 1150 && n <= 1252);
      apb(1'b0, `SCP_APB_RES, 32'h0, rd, e);
      chk("last_res", 32'h87e5, rd);
      cmd(`SCP_SR_NOP, 11'h0);
      chk("adc_rb", 32'h87e5, r);
      $display("test adc done");
      @(posedge i_clk_sys);
      i_reset_n <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      chk("pin_reset", 32'h0, {o_ref_en, o_dac_en, o_config_pin_oe});
      i_reset_n <= 1'b1;
      $display("test reset pin done");
      finish_test();
   end
endmodule // tb
